// file: rtl/scfs_pkg.sv
// Constants, state encoding and input carrier for the short-circuit fault sequencer
package scfs_pkg;
	// Clock and interval figures
	localparam int SCFS_CLK_NS = 10;
	localparam int SCFS_MS_NS = 1000000;
	localparam int SCFS_CYCLES_PER_MS = SCFS_MS_NS / SCFS_CLK_NS;
	localparam logic [8:0] SCFS_BLANK_SHORT_MS = 9'h001;
	localparam logic [8:0] SCFS_BLANK_LONG_MS = 9'h1e0;
	localparam logic [8:0] SCFS_HICCUP_MS = 9'h1e0;
	// Event counter
	localparam logic [3:0] SCFS_COUNT_LIMIT = 4'ha;
	localparam logic [3:0] SCFS_COUNT_FLOOR = 4'h0;
	localparam logic [15:0] SCFS_DEC_MS_RST = 16'h000a;
	// Register byte offsets
	localparam logic [3:0] SCFS_ADR_STATUS = 4'h0;
	localparam logic [3:0] SCFS_ADR_DEC_MS = 4'h4;
	// Status field positions
	localparam int SCFS_ST_STATE_LSB = 0;
	localparam int SCFS_ST_FAULT_BIT = 3;
	localparam int SCFS_ST_START_BIT = 4;
	localparam int SCFS_ST_UV_BIT = 5;
	localparam int SCFS_ST_HICCUP_BIT = 6;
	localparam int SCFS_ST_COUNT_LSB = 8;

	// Gray codes along ramp, normal, blank, fault
	typedef enum logic [2:0] {
		SCFS_ST_RAMP = 3'h0,
		SCFS_ST_NORMAL = 3'h1,
		SCFS_ST_BLANK = 3'h3,
		SCFS_ST_FAULT = 3'h7,
		SCFS_ST_UVWAIT = 3'h2
	} scfs_state_t;

	// Synchronised protection inputs
	typedef struct packed {
		logic fb_high;
		logic sc_high;
		logic bus_overvoltage_trip;
		logic uv;
		logic oc;
		logic hiccup;
	} scfs_prot_in_t;
endpackage

// file: rtl/scfs_sequencer.sv
// Short-circuit protection sequencer with Wishbone status and interval registers
// Summary of operation
// [RULE1] Captured low on short_circuit_in latches short-circuit mode and stops switching.
// [RULE2] Blanking holds switching off: 1 ms with select low, 480 ms with select high.
// [RULE3] Bus over- and under-voltage stay monitored and acted on during blanking.
// [RULE4] Blanking is prolonged until feedback and short-circuit inputs both read high.
// [RULE5] After blanking with both inputs high, switching resumes in soft-start ramp-up.
// [RULE6] Feedback and short-circuit low during ramp-up abort it into short-circuit mode.
// [RULE7] Event counter counts short-circuit entries only in latch-off response.
// [RULE8] Counter reaching 10 enters the latched fault state, fault output high.
// [RULE9] After a clean ramp-up the counter decrements at a short interval.
// [RULE10] Hiccup response retries after the hiccup delay forever, never latching.
// [RULE11] Startup-complete is low from power-on and throughout ramp-up.
// [RULE12] Startup-complete goes high at normal mode and stays high outside exceptions.
// [RULE13] Latched fault state forces startup-complete low.
// [RULE14] Blanking and hiccup delay force startup-complete low.
// [RULE15] Latched fault state delivers no switching and holds fault output high.
// [RULE16] Only power-on reset leaves the latched fault state.
// [RULE17] Bus under-voltage never latches the fault state.
// [RULE18] Over-current trip latches the fault with select low.
// [RULE19] Bus over-voltage latches the fault regardless of select.
// [RULE20] Outside circuit pulls feedback and short-circuit low on severe over-current.
// [RULE21] Hiccup response stops switching about 480 ms with fault output low.
// [RULE22] Inputs synchronised; millisecond intervals come from a parameter prescaler.
// [RULE23] Decrement interval and counter floor are parameters.
//
// Our own choices: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
module scfs_sequencer import scfs_pkg::*; #(
	parameter int CYCLES_PER_MS = SCFS_CYCLES_PER_MS,
	parameter logic [3:0] COUNT_FLOOR = SCFS_COUNT_FLOOR,
	parameter logic [15:0] DEC_MS_DEFAULT = SCFS_DEC_MS_RST
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic feedback_in_i,
	input wire logic short_circuit_in_i,
	input wire logic bus_overvoltage_trip_i,
	input wire logic bus_undervoltage_trip_i,
	input wire logic overcurrent_trip_i,
	input wire logic protection_response_select_i,
	input wire logic ramp_done_i,
	output logic gate_enable_o,
	output logic ramp_active_o,
	output logic startup_complete_o,
	output logic fault_o,
	input wire logic [31:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic wb_ack_o,
	output logic [31:0] wb_dat_o
);
	logic [5:0] sync_a;
	logic [5:0] sync_b;
	scfs_prot_in_t pin;
	scfs_state_t state;
	scfs_state_t next_state;
	logic enter_sc;
	logic [3:0] sc_count;
	logic [31:0] tick_cnt;
	logic ms_tick;
	logic [8:0] blank_ms;
	logic [8:0] ms_cnt;
	logic blank_done;
	logic [15:0] dec_ms;
	logic [15:0] dec_cnt;
	logic dec_fire;

	// Response to a trip that may latch: fault in latch-off when latch_now is set, otherwise blanking
	function automatic scfs_state_t scfs_trip_target(input logic hiccup, input logic latch_now);
		scfs_trip_target = (hiccup || !latch_now) ? SCFS_ST_BLANK : SCFS_ST_FAULT;
	endfunction

	// Two-flop synchronisers for the six protection inputs; ramp_done_i is used unsynchronised
	// Reset to the idle levels: feedback and short-circuit high, every trip low,
	// so that no false over-voltage latches the fault at reset release
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync_a <= 6'h30;
			sync_b <= 6'h30;
		end else begin
			sync_a <= {feedback_in_i, short_circuit_in_i, bus_overvoltage_trip_i,
				bus_undervoltage_trip_i, overcurrent_trip_i, protection_response_select_i};
			sync_b <= sync_a; // [RULE22]
		end
	end
	assign pin = scfs_prot_in_t'(sync_b);

	// Millisecond prescaler, restarted on every state change
	always_ff @(posedge clk_i) begin
		if (rst_i || state != next_state) begin
			tick_cnt <= 32'h0;
		end else if (ms_tick) begin
			tick_cnt <= 32'h0;
		end else begin
			tick_cnt <= tick_cnt + 32'h1;
		end
	end
	assign ms_tick = (tick_cnt == 32'(CYCLES_PER_MS - 1)); // [RULE22]

	// Blanking length chosen on entry and its elapsed milliseconds
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			blank_ms <= SCFS_BLANK_SHORT_MS;
			ms_cnt <= 9'h0;
		end else begin
			if (next_state == SCFS_ST_BLANK && state != SCFS_ST_BLANK) begin
				blank_ms <= pin.hiccup ? SCFS_HICCUP_MS : SCFS_BLANK_SHORT_MS; // [RULE2] [RULE21]
			end
			if (state != SCFS_ST_BLANK) begin
				ms_cnt <= 9'h0;
			end else if (ms_tick && !blank_done) begin
				ms_cnt <= ms_cnt + 9'h1;
			end
		end
	end
	assign blank_done = (ms_cnt >= blank_ms);

	// State transition decision
	always_comb begin
		next_state = state;
		enter_sc = 1'b0;
		if (state == SCFS_ST_FAULT) begin
			next_state = SCFS_ST_FAULT; // [RULE16]
		end else if (pin.bus_overvoltage_trip) begin
			next_state = SCFS_ST_FAULT; // [RULE19] [RULE3]
		end else begin
			case (state)
				SCFS_ST_RAMP, SCFS_ST_NORMAL: begin
					if (pin.oc) begin
						next_state = scfs_trip_target(pin.hiccup, 1'b1); // [RULE18]
					end else if (!pin.sc_high) begin
						// Low feedback with low short-circuit aborts ramp-up too [RULE6]
						enter_sc = 1'b1; // [RULE1]
						next_state = scfs_trip_target(pin.hiccup,
							sc_count + 4'h1 >= SCFS_COUNT_LIMIT); // [RULE8] [RULE10]
					end else if (pin.uv) begin
						next_state = SCFS_ST_UVWAIT; // [RULE17]
					end else if (state == SCFS_ST_RAMP && ramp_done_i) begin
						next_state = SCFS_ST_NORMAL;
					end
				end
				SCFS_ST_BLANK: begin
					if (blank_done && pin.fb_high && pin.sc_high && !pin.uv) begin
						next_state = SCFS_ST_RAMP; // [RULE4] [RULE5]
					end
				end
				SCFS_ST_UVWAIT: begin
					if (!pin.uv) begin
						next_state = SCFS_ST_RAMP; // [RULE17]
					end
				end
				default: begin
					next_state = SCFS_ST_FAULT;
				end
			endcase
		end
	end

	// State register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= SCFS_ST_RAMP;
		end else begin
			state <= next_state;
		end
	end

	// Decrement interval timer, runs only in normal mode
	always_ff @(posedge clk_i) begin
		if (rst_i || state != SCFS_ST_NORMAL || dec_fire) begin
			dec_cnt <= 16'h0;
		end else if (ms_tick) begin
			dec_cnt <= dec_cnt + 16'h1;
		end
	end
	assign dec_fire = (state == SCFS_ST_NORMAL) && (dec_cnt >= dec_ms) && ms_tick; // [RULE9]

	// Short-circuit event counter
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sc_count <= 4'h0;
		end else if (enter_sc && !pin.hiccup) begin
			if (sc_count < SCFS_COUNT_LIMIT) begin
				sc_count <= sc_count + 4'h1; // [RULE7]
			end
		end else if (dec_fire && sc_count > COUNT_FLOOR) begin
			sc_count <= sc_count - 4'h1; // [RULE9] [RULE23]
		end
	end

	// Registered outputs follow the next state
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			gate_enable_o <= 1'b0;
			ramp_active_o <= 1'b0;
			startup_complete_o <= 1'b0; // [RULE11]
			fault_o <= 1'b0;
		end else begin
			gate_enable_o <= (next_state == SCFS_ST_RAMP) || (next_state == SCFS_ST_NORMAL); // [RULE15]
			ramp_active_o <= (next_state == SCFS_ST_RAMP);
			// Low in ramp, blanking, hiccup delay and fault [RULE12] [RULE13] [RULE14]
			startup_complete_o <= (next_state == SCFS_ST_NORMAL) ||
				(next_state == SCFS_ST_UVWAIT);
			fault_o <= (next_state == SCFS_ST_FAULT); // [RULE15] [RULE21]
		end
	end

	// Wishbone slave: one wait state, unmapped reads return zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
			dec_ms <= DEC_MS_DEFAULT;
		end else begin
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
			wb_dat_o <= 32'h0;
			if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
				if (wb_we_i && wb_adr_i[3:0] == SCFS_ADR_DEC_MS) begin
					if (wb_sel_i[0]) begin
						dec_ms[7:0] <= wb_dat_i[7:0]; // [RULE23]
					end
					if (wb_sel_i[1]) begin
						dec_ms[15:8] <= wb_dat_i[15:8];
					end
				end else if (!wb_we_i && wb_adr_i[3:0] == SCFS_ADR_STATUS) begin
					wb_dat_o[SCFS_ST_STATE_LSB +: 3] <= state;
					wb_dat_o[SCFS_ST_FAULT_BIT] <= fault_o;
					wb_dat_o[SCFS_ST_START_BIT] <= startup_complete_o;
					wb_dat_o[SCFS_ST_UV_BIT] <= pin.uv;
					wb_dat_o[SCFS_ST_HICCUP_BIT] <= pin.hiccup;
					wb_dat_o[SCFS_ST_COUNT_LSB +: 4] <= sc_count;
				end else if (!wb_we_i && wb_adr_i[3:0] == SCFS_ADR_DEC_MS) begin
					wb_dat_o[15:0] <= dec_ms;
				end
			end
		end
	end

	// Checks on the protection sequence
	a_fault_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
		state == SCFS_ST_FAULT |=> state == SCFS_ST_FAULT) // [RULE16]
		else $error("latched fault state was left");
	a_fault_outputs: assert property (@(posedge clk_i) disable iff (rst_i)
		state == SCFS_ST_FAULT |-> fault_o && !gate_enable_o && !startup_complete_o) // [RULE13]
		else $error("fault state outputs wrong");
	a_sc_entry: assert property (@(posedge clk_i) disable iff (rst_i)
		(state == SCFS_ST_RAMP || state == SCFS_ST_NORMAL) && !pin.sc_high && !pin.oc
		|=> (state == SCFS_ST_BLANK || state == SCFS_ST_FAULT) && !gate_enable_o) // [RULE1]
		else $error("short circuit did not stop switching");
	a_blank_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
		state == SCFS_ST_BLANK |-> !gate_enable_o && !startup_complete_o) // [RULE14]
		else $error("switching or startup high in blanking");
	a_blank_extend: assert property (@(posedge clk_i) disable iff (rst_i)
		state == SCFS_ST_BLANK && (!pin.fb_high || !pin.sc_high) |=> state != SCFS_ST_RAMP) // [RULE4]
		else $error("blanking ended with an input low");
	a_blank_length: assert property (@(posedge clk_i) disable iff (rst_i)
		state == SCFS_ST_BLANK && next_state == SCFS_ST_RAMP
		|-> ms_cnt >= (pin.hiccup ? SCFS_HICCUP_MS : SCFS_BLANK_SHORT_MS)) // [RULE2]
		else $error("blanking shorter than selected");
	a_ovp_latch: assert property (@(posedge clk_i) disable iff (rst_i)
		pin.bus_overvoltage_trip |=> state == SCFS_ST_FAULT ##1 fault_o) // [RULE19]
		else $error("over-voltage did not latch");
	a_count_limit: assert property (@(posedge clk_i) disable iff (rst_i)
		sc_count == SCFS_COUNT_LIMIT |-> state == SCFS_ST_FAULT) // [RULE8]
		else $error("counter at limit without fault");
	a_hiccup_count: assert property (@(posedge clk_i) disable iff (rst_i)
		enter_sc && pin.hiccup |=> $stable(sc_count) && state == SCFS_ST_BLANK) // [RULE10]
		else $error("hiccup entry counted or latched");
	a_uv_nolatch: assert property (@(posedge clk_i) disable iff (rst_i)
		pin.uv && !pin.bus_overvoltage_trip && !pin.oc && pin.sc_high && state != SCFS_ST_FAULT
		|=> state != SCFS_ST_FAULT) // [RULE17]
		else $error("under-voltage latched a fault");
	a_ramp_startup: assert property (@(posedge clk_i) disable iff (rst_i)
		state == SCFS_ST_RAMP |-> !startup_complete_o) // [RULE11]
		else $error("startup high during ramp-up");
	// Outputs are registered from the next state, so they follow one edge later
	a_ramp_flag: assert property (@(posedge clk_i) disable iff (rst_i)
		next_state == SCFS_ST_RAMP |=> ramp_active_o && gate_enable_o) // [RULE5]
		else $error("ramp-up entered without switching");
	a_oc_latch: assert property (@(posedge clk_i) disable iff (rst_i)
		pin.oc && !pin.hiccup && (state == SCFS_ST_RAMP || state == SCFS_ST_NORMAL)
		|=> state == SCFS_ST_FAULT) // [RULE18]
		else $error("over-current did not latch in latch-off response");
	a_normal_startup: assert property (@(posedge clk_i) disable iff (rst_i)
		state == SCFS_ST_NORMAL |-> startup_complete_o && !ramp_active_o) // [RULE12]
		else $error("startup low in normal mode");
	a_hiccup_nolatch: assert property (@(posedge clk_i) disable iff (rst_i)
		pin.hiccup && !pin.bus_overvoltage_trip && state != SCFS_ST_FAULT
		|=> state != SCFS_ST_FAULT) // [RULE10]
		else $error("hiccup response latched a fault");
	a_dec_step: assert property (@(posedge clk_i) disable iff (rst_i)
		dec_fire && !enter_sc && sc_count > COUNT_FLOOR
		|=> sc_count == $past(sc_count) - 4'h1) // [RULE9]
		else $error("event counter did not decrement");
	c_hiccup_retry: cover property (@(posedge clk_i) disable iff (rst_i)
		state == SCFS_ST_BLANK && pin.hiccup ##1 state == SCFS_ST_RAMP);
	c_latch_by_count: cover property (@(posedge clk_i) disable iff (rst_i)
		enter_sc ##1 state == SCFS_ST_FAULT);
	c_decrement: cover property (@(posedge clk_i) disable iff (rst_i)
		dec_fire && sc_count > COUNT_FLOOR);
	c_normal_reached: cover property (@(posedge clk_i) disable iff (rst_i)
		state == SCFS_ST_RAMP ##1 state == SCFS_ST_NORMAL);
endmodule

// file: tb/scfs_far_model.sv
// Far-side model: short-circuit comparator and switching engine ramp
`timescale 1ns/1ps
module scfs_far_model #(
	parameter int RAMP_CYC = 20
) (
	input wire logic clk_i,
	input wire logic short_i,
	input wire logic ramp_active_i,
	output logic feedback_in_o,
	output logic short_circuit_in_o,
	output logic ramp_done_o
);
	int cnt = 0;
	// Severe overcurrent pulls both lines low through isolating diodes
	assign feedback_in_o = !short_i;
	assign short_circuit_in_o = !short_i;
	// Ramp finishes a fixed time after the engine starts it
	always @(posedge clk_i) begin
		cnt <= ramp_active_i ? cnt + 1 : 0;
		ramp_done_o <= ramp_active_i && cnt >= RAMP_CYC;
	end
endmodule

// file: tb/scfs_sequencer_tb_top.sv
// Self-checking bench for the short-circuit fault sequencer
`timescale 1ns/1ps
module scfs_sequencer_tb_top import scfs_pkg::*; ;
	localparam int MS = 10;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic short = 1'b0, bus_overvoltage_trip = 1'b0, uv = 1'b0, oc = 1'b0, psel = 1'b0;
	logic fb, sc, rd, gate, ramp, su, flt, ack, we = 1'b0, cyc = 1'b0, stb = 1'b0;
	logic [31:0] adr = 32'h0, dat = 32'h0, rdat, q;
	logic [3:0] bsel = 4'h3;
	int error_cnt = 0, checked = 0, n;

	scfs_sequencer #(.CYCLES_PER_MS(MS)) uut (.clk_i(clk_i), .rst_i(rst_i),
		.feedback_in_i(fb), .short_circuit_in_i(sc), .bus_overvoltage_trip_i(bus_overvoltage_trip),
		.bus_undervoltage_trip_i(uv), .overcurrent_trip_i(oc),
		.protection_response_select_i(psel), .ramp_done_i(rd), .gate_enable_o(gate),
		.ramp_active_o(ramp), .startup_complete_o(su), .fault_o(flt), .wb_adr_i(adr),
		.wb_dat_i(dat), .wb_sel_i(bsel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_ack_o(ack), .wb_dat_o(rdat));
	scfs_far_model #(.RAMP_CYC(20)) far (.clk_i(clk_i), .short_i(short), .ramp_active_i(ramp),
		.feedback_in_o(fb), .short_circuit_in_o(sc), .ramp_done_o(rd));

	// Free-running 100 MHz clock
	initial begin
		forever #5 clk_i = ~clk_i;
	end

	task automatic conclude();
		if (error_cnt == 0 && checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge clk_i);
	endtask
	// Bounded wait for the gate to reach a level, leaves cycles spent in n
	task automatic wait_gate(input logic v);
		for (n = 0; n < 6000 && gate !== v; n++) @(posedge clk_i);
		chk(gate, v);
	endtask
	// Classic Wishbone single cycle, held until ack is sampled
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		int i;
		@(posedge clk_i);
		{adr, dat, we, cyc, stb} <= {28'h0, a, d, w, 2'b11};
		@(posedge clk_i);
		for (i = 0; i < 50 && ack !== 1'b1; i++) @(posedge clk_i);
		chk(ack, 1'b1);
		q = rdat;
		{cyc, stb} <= 2'b00;
		@(posedge clk_i);
	endtask
	task automatic do_reset(input logic s);
		@(posedge clk_i);
		{rst_i, short, bus_overvoltage_trip, uv, oc, psel} <= {1'b1, 4'h0, s};
		tick(6);
		rst_i <= 1'b0;
		tick(5);
	endtask
	task automatic sc_hit();
		short <= 1'b1;
		tick(3);
		short <= 1'b0;
	endtask

	// Latch-off: blanking, prolonging, ramp abort, counting up to fault
	task automatic t_latch();
		int k;
		do_reset(1'b0);
		chk(su, 1'b0);
		chk(ramp, 1'b1);
		tick(30);
		chk(su, 1'b1);
		short <= 1'b1;
		wait_gate(1'b0);
		tick(2);
		chk(su, 1'b0);
		tick(30);
		chk(gate, 1'b0);
		short <= 1'b0;
		wait_gate(1'b1);
		chk(ramp, 1'b1);
		wb(1'b0, SCFS_ADR_STATUS, 32'h0);
		chk(q[11:8], 4'h1);
		sc_hit();
		wait_gate(1'b0);
		wait_gate(1'b1);
		chk(n >= MS && n <= MS + 6, 1'b1);
		for (k = 2; k < 10; k++) begin
			chk(flt, 1'b0);
			sc_hit();
			wait_gate(1'b0);
			if (k < 9) wait_gate(1'b1);
		end
		tick(20);
		chk({flt, gate, su}, 3'h4);
		wb(1'b0, SCFS_ADR_STATUS, 32'h0);
		chk({q[11:8], q[2:0]}, {SCFS_COUNT_LIMIT, SCFS_ST_FAULT});
		psel <= 1'b1;
		wb(1'b1, SCFS_ADR_STATUS, 32'h0);
		tick(100);
		chk({flt, gate}, 2'h2);
		wb(1'b0, 4'h8, 32'h0);
		chk(q, 32'h0);
	endtask

	// Counter decrement after a clean ramp
	task automatic t_dec();
		do_reset(1'b0);
		wb(1'b0, SCFS_ADR_DEC_MS, 32'h0);
		chk(q[15:0], SCFS_DEC_MS_RST);
		wb(1'b1, SCFS_ADR_DEC_MS, 32'h1);
		sc_hit();
		wait_gate(1'b0);
		wait_gate(1'b1);
		tick(60);
		wb(1'b0, SCFS_ADR_STATUS, 32'h0);
		chk(q[11:8], 4'h0);
	endtask

	// Hiccup: long delay, retries, never latching
	task automatic t_hiccup();
		int k;
		do_reset(1'b1);
		tick(30);
		for (k = 0; k < 2; k++) begin
			sc_hit();
			wait_gate(1'b0);
			chk(su, 1'b0);
			wait_gate(1'b1);
			chk(n >= MS * 480 && n <= MS * 480 + 6, 1'b1);
			chk(flt, 1'b0);
		end
		wb(1'b0, SCFS_ADR_STATUS, 32'h0);
		chk(q[11:8], 4'h0);
	endtask

	// Over-voltage, over-current and under-voltage responses
	task automatic t_faults();
		do_reset(1'b1);
		bus_overvoltage_trip <= 1'b1;
		tick(8);
		chk(flt, 1'b1);
		do_reset(1'b0);
		oc <= 1'b1;
		tick(8);
		chk(flt, 1'b1);
		do_reset(1'b0);
		uv <= 1'b1;
		tick(8);
		chk({flt, gate}, 2'h0);
		uv <= 1'b0;
		wait_gate(1'b1);
		sc_hit();
		uv <= 1'b1;
		tick(40);
		chk(gate, 1'b0);
		bus_overvoltage_trip <= 1'b1;
		tick(8);
		chk(flt, 1'b1);
	endtask

	initial begin
		t_latch();
		t_dec();
		t_hiccup();
		t_faults();
		conclude();
	end
	// Watchdog well beyond the expected run length
	initial begin
		#600000;
		error_cnt++;
		conclude();
	end
endmodule
